// ### logic/agt_pkg.sv
package agt_pkg;

  // Card-side I/O offsets
  localparam logic [3:0] OFS_AD_LO = 4'h4;
  localparam logic [3:0] OFS_AD_HI = 4'h5;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
  localparam logic [3:0] OFS_GAIN = 4'h9;
  localparam logic [3:0] OFS_CHAN = 4'hA;
  localparam logic [3:0] OFS_MODE = 4'hB;
  localparam logic [3:0] OFS_STRIG = 4'hC;

  // Field layout
  localparam int READY_BIT = 4;
  localparam int GAIN_W = 4;
  localparam int CHAN_W = 4;
  localparam int MODE_W = 3;
  localparam int RES_W = 12;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Mode select codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SW_POLL = 3'h1;
  localparam logic [2:0] MODE_PACER_DMA = 3'h2;
  localparam logic [2:0] MODE_PACER_INT = 3'h6;

  // Pin synchroniser slots
  localparam int PIN_EXT = 0;
  localparam int PIN_PACER = 1;
  localparam int PIN_JUMP = 2;
  localparam int PIN_DIFF = 3;
  localparam int PIN_N = 4;

  // Host register map (AXI4-Lite byte addresses)
  localparam logic [4:0] HREG_CMD = 5'h00;
  localparam logic [4:0] HREG_STATUS = 5'h04;
  localparam logic [4:0] HREG_EVENTS = 5'h08;
  localparam logic [4:0] HREG_MASK = 5'h0C;
  localparam logic [4:0] HREG_DMA = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Host command ops
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_CONVERT = 2'h2;

  // Host event bits
  localparam int EV_DONE = 0;
  localparam int EV_IRQ = 1;
  localparam int EV_DMA = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_N = 4;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int GAIN_SETTLE_US = 1300;
  localparam int MUX_SETTLE_US = 100;
  localparam int SETTLE_W = 18;
  localparam int POLL_LIMIT_DEF = 1000;

  typedef enum logic [3:0] {
    AD_IDLE = 4'b0001,
    AD_CONV = 4'b0010,
    AD_DMA_LO = 4'b0100,
    AD_DMA_HI = 4'b1000
  } agt_dev_state_e;

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_SETTLE = 5'b00010,
    H_WR = 5'b00100,
    H_RD = 5'b01000,
    H_RDW = 5'b10000
  } agt_host_state_e;

endpackage

// ### logic/agt_io_if.sv
interface agt_io_if;
  logic [3:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic irq;
  logic dma_req;
  logic dma_ack;

  modport dev (
    input io_addr, io_wdata, io_wr, io_rd, dma_ack,
    output io_rdata, irq, dma_req
  );

  modport host (
    output io_addr, io_wdata, io_wr, io_rd, dma_ack,
    input io_rdata, irq, dma_req
  );
endinterface

// ### logic/agt_host.sv
module agt_host
  import agt_pkg::*;
#(
  parameter int GAIN_SETTLE_CYC = GAIN_SETTLE_US * CLK_MHZ,
  parameter int MUX_SETTLE_CYC = MUX_SETTLE_US * CLK_MHZ,
  parameter int POLL_LIMIT = POLL_LIMIT_DEF
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq_out,
  // Card bus
  agt_io_if.host bus
);

  typedef struct packed {
    logic awv, wv, awrdy, wrdy, arrdy, bvalid, rvalid;
    logic [4:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [EV_N-1:0] mask, events;
    logic irq_out, irq_prev;
    agt_host_state_e state;
    logic [1:0] op;
    logic poll_phase;
    logic [3:0] io_addr;
    logic [7:0] io_wdata, rd_byte;
    logic io_wr, io_rd, dma_ack, dma_cap, dma_hi;
    logic [SETTLE_W-1:0] settle;
    logic [15:0] polls;
    logic [RES_W-1:0] result, dma_word;
    logic addr_err;
  } agt_host_s;

  agt_host_s q, d;
  logic cmd_go;

  always_comb begin
    d = q;
    cmd_go = 1'b0;
    d.irq_prev = bus.irq;
    if (q.settle != '0) begin
      d.settle = q.settle - 1'b1;
    end
    // AXI write channels
    if (s_axi_awvalid && q.awrdy) begin
      d.awv = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wrdy) begin
      d.wv = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.awv && q.wv && !q.bvalid) begin
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awaddr == HREG_CMD) begin
        cmd_go = q.state == H_IDLE;
      end else if (q.awaddr == HREG_MASK) begin
        if (q.wstrb[0]) begin
          d.mask = q.wdata[EV_N-1:0];
        end
      end else if (q.awaddr == HREG_STATUS || q.awaddr == HREG_EVENTS || q.awaddr == HREG_DMA) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    // AXI read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      if (s_axi_araddr == HREG_CMD) begin
        d.rdata = '0;
      end else if (s_axi_araddr == HREG_STATUS) begin
        d.rdata = {4'h0, q.result, q.rd_byte, 6'h00, q.addr_err, q.state != H_IDLE};
      end else if (s_axi_araddr == HREG_EVENTS) begin
        d.rdata = {28'h0000000, q.events};
        d.events = '0;
      end else if (s_axi_araddr == HREG_MASK) begin
        d.rdata = {28'h0000000, q.mask};
      end else if (s_axi_araddr == HREG_DMA) begin
        d.rdata = {20'h00000, q.dma_word};
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    // Interrupt line edge sets an event
    if (bus.irq && !q.irq_prev) begin
      d.events[EV_IRQ] = 1'b1; // [R17]
    end
    // Two DMA bytes per result, low first
    d.dma_ack = 1'b0;
    d.dma_cap = q.dma_ack;
    if (bus.dma_req && !q.dma_ack && !q.dma_cap && q.state == H_IDLE) begin
      d.dma_ack = 1'b1;
    end
    if (q.dma_cap) begin
      d.dma_hi = !q.dma_hi;
      if (q.dma_hi) begin
        d.dma_word[RES_W-1:8] = bus.io_rdata[RES_W-9:0];
        d.events[EV_DMA] = 1'b1;
      end else begin
        d.dma_word[7:0] = bus.io_rdata;
      end
    end
    // Command sequencer
    d.io_wr = 1'b0;
    d.io_rd = 1'b0;
    case (q.state)
      H_IDLE: begin
        if (cmd_go) begin
          d.op = q.wdata[17:16];
          d.io_addr = q.wdata[3:0];
          d.io_wdata = q.wdata[15:8];
          d.poll_phase = 1'b0;
          if (q.wdata[17:16] == OP_CONVERT) begin
            d.io_addr = OFS_STRIG;
            d.state = H_SETTLE;
          end else if (q.wdata[17:16] == OP_READ) begin
            d.io_rd = 1'b1;
            d.state = H_RD;
          end else begin
            d.io_wr = 1'b1;
            d.state = H_WR;
          end
        end
      end
      H_SETTLE: begin
        if (q.settle == '0) begin
          d.io_wr = 1'b1; // [R4] [R6]
          d.state = H_WR;
        end
      end
      H_WR: begin
        if (q.io_addr == OFS_GAIN && q.settle < SETTLE_W'(GAIN_SETTLE_CYC)) begin
          d.settle = SETTLE_W'(GAIN_SETTLE_CYC); // [R4]
        end else if (q.io_addr == OFS_CHAN && q.settle < SETTLE_W'(MUX_SETTLE_CYC)) begin
          d.settle = SETTLE_W'(MUX_SETTLE_CYC); // [R6]
        end
        if (q.op == OP_CONVERT) begin
          d.io_addr = OFS_AD_HI;
          d.io_rd = 1'b1;
          d.polls = '0;
          d.state = H_RD;
        end else begin
          d.events[EV_DONE] = 1'b1;
          d.state = H_IDLE;
        end
      end
      H_RD: begin
        d.state = H_RDW;
      end
      H_RDW: begin
        d.rd_byte = bus.io_rdata;
        d.state = H_IDLE;
        if (q.op != OP_CONVERT || q.poll_phase) begin
          d.events[EV_DONE] = 1'b1;
          if (q.poll_phase) begin
            d.result[7:0] = bus.io_rdata;
          end
        end else if (!bus.io_rdata[READY_BIT]) begin
          d.result[RES_W-1:8] = bus.io_rdata[RES_W-9:0]; // [R13]
          d.addr_err = 1'b0;
          d.poll_phase = 1'b1;
          d.io_addr = OFS_AD_LO;
          d.io_rd = 1'b1;
          d.state = H_RD;
        end else if (q.polls == 16'(POLL_LIMIT - 1)) begin
          d.addr_err = 1'b1; // [R14]
          d.events[EV_TIMEOUT] = 1'b1;
          d.events[EV_DONE] = 1'b1;
        end else begin
          d.polls = q.polls + 16'h0001; // [R13]
          d.io_rd = 1'b1;
          d.state = H_RD;
        end
      end
      default: begin
        d.state = H_IDLE;
      end
    endcase
    d.awrdy = !d.awv && !d.bvalid;
    d.wrdy = !d.wv && !d.bvalid;
    d.arrdy = !d.rvalid;
    d.irq_out = |(d.events & d.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.state <= H_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign irq_out = q.irq_out;
  assign bus.io_addr = q.io_addr;
  assign bus.io_wdata = q.io_wdata;
  assign bus.io_wr = q.io_wr;
  assign bus.io_rd = q.io_rd;
  assign bus.dma_ack = q.dma_ack;

endmodule

// ### logic/agt_dev.sv
// Function
// R1 - Gain register takes low four bits only
// R2 - Low-gain codes: gains 1-8, unipolar, half
// R3 - High-gain codes: gains 1-1000, unipolar, 0.5-500
// R4 - Host waits gain settling before trigger
// R5 - Channel select: 16 single or 8 pairs
// R6 - Host waits mux settling before trigger
// R7 - Mode register uses low three bits
// R8 - Internal jumper: off, sw, pacer DMA/int
// R9 - External jumper: off, ext DMA/int
// R10 - A trigger write of any data starts one conversion, but only in software poll mode with the internal jumper
// R11 - Ready flag in result high byte
// R12 - Pacer output starts conversions in pacer modes
// R13 - Host polls ready low before reading
// R14 - Host flags address error on timeout
// R15 - Trigger stage then transfer stage
// R16 - Ready high while busy, low when valid
// R17 - Interrupt bit set per result, write clears
// R18 - DMA mode issues two byte requests
// R19 - Mode resets to disabled
module agt_dev
  import agt_pkg::*;
#(
  parameter bit HIGH_GAIN = 1'b0
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Host bus
  agt_io_if.dev bus,
  // Converter
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  // Gain stage
  output logic [GAIN_W-1:0] gain_code,
  output logic bipolar_range,
  output logic unipolar_range,
  output logic [1:0] gain_step,
  output logic gain_half,
  // Multiplexer
  output logic [CHAN_W-1:0] mux_sel,
  // Pins and jumpers
  input wire logic trigger_source_jumper,
  input wire logic diff_config,
  input wire logic pacer_out,
  input wire logic ext_trigger
);

  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic pacer_prev;
    logic ext_prev;
    logic [GAIN_W-1:0] gain;
    logic [CHAN_W-1:0] chan;
    logic [MODE_W-1:0] mode;
    logic [RES_W-1:0] result;
    logic ready;
    logic irq_pend;
    logic dma_req;
    logic [7:0] rdata;
    logic conv_start;
    logic [CHAN_W-1:0] mux_sel;
    logic bipolar;
    logic unipolar;
    logic half;
    logic [1:0] step;
    agt_dev_state_e state;
  } agt_dev_s;

  agt_dev_s q, d;
  logic ext_sel;
  logic pacer_rise;
  logic ext_rise;
  logic sw_hit;
  logic sw_en;
  logic hw_trig;
  logic dma_mode;
  logic int_mode;
  logic trigger;

  always_comb begin
    d = q;
    d.conv_start = 1'b0;
    // Two-stage pin capture
    d.sync1[PIN_EXT] = ext_trigger;
    d.sync1[PIN_PACER] = pacer_out;
    d.sync1[PIN_JUMP] = trigger_source_jumper;
    d.sync1[PIN_DIFF] = diff_config;
    d.sync2 = q.sync1;
    d.pacer_prev = q.sync2[PIN_PACER];
    d.ext_prev = q.sync2[PIN_EXT];
    pacer_rise = q.sync2[PIN_PACER] && !q.pacer_prev;
    ext_rise = q.sync2[PIN_EXT] && !q.ext_prev;
    ext_sel = q.sync2[PIN_JUMP];

    // Mode decode against jumper
    sw_en = !ext_sel && q.mode == MODE_SW_POLL; // [R8]
    dma_mode = q.mode == MODE_PACER_DMA; // [R8] [R9]
    int_mode = q.mode == MODE_PACER_INT; // [R8] [R9]
    hw_trig = 1'b0;
    if (dma_mode || int_mode) begin
      if (ext_sel) begin
        hw_trig = ext_rise; // [R9]
      end else begin
        hw_trig = pacer_rise; // [R12]
      end
    end

    // Register writes
    sw_hit = 1'b0;
    if (bus.io_wr) begin
      if (bus.io_addr == OFS_GAIN) begin
        d.gain = bus.io_wdata[GAIN_W-1:0]; // [R1]
      end else if (bus.io_addr == OFS_CHAN) begin
        d.chan = bus.io_wdata[CHAN_W-1:0]; // [R5]
      end else if (bus.io_addr == OFS_MODE) begin
        d.mode = bus.io_wdata[MODE_W-1:0]; // [R7]
      end else if (bus.io_addr == OFS_STRIG) begin
        sw_hit = 1'b1; // [R10]
      end else if (bus.io_addr == OFS_IRQ_CLR) begin
        d.irq_pend = 1'b0; // [R17]
      end
    end
    trigger = (sw_hit && sw_en) || hw_trig;

    // Register reads
    if (bus.io_rd) begin
      if (bus.io_addr == OFS_AD_LO) begin
        d.rdata = q.result[7:0];
      end else if (bus.io_addr == OFS_AD_HI) begin
        d.rdata = {3'b000, q.ready, q.result[RES_W-1:8]}; // [R11]
      end else begin
        d.rdata = BYTE_ZERO;
      end
    end

    // Trigger stage then transfer stage
    case (q.state)
      AD_IDLE: begin
        if (trigger) begin
          d.conv_start = 1'b1; // [R10] [R15]
          d.ready = 1'b1; // [R16]
          d.state = AD_CONV;
        end
      end
      AD_CONV: begin
        if (conv_done) begin
          d.result = conv_data;
          d.ready = 1'b0; // [R16]
          if (int_mode) begin
            d.irq_pend = 1'b1; // [R17]
          end
          if (dma_mode) begin
            d.dma_req = 1'b1; // [R18]
            d.state = AD_DMA_LO;
          end else begin
            d.state = AD_IDLE; // [R15]
          end
        end
      end
      AD_DMA_LO: begin
        if (q.dma_req && bus.dma_ack) begin
          d.rdata = q.result[7:0]; // [R18]
          d.dma_req = 1'b0;
          d.state = AD_DMA_HI;
        end
      end
      AD_DMA_HI: begin
        if (q.dma_req && bus.dma_ack) begin
          d.rdata = {4'h0, q.result[RES_W-1:8]}; // [R18]
          d.dma_req = 1'b0;
          d.state = AD_IDLE;
        end else begin
          d.dma_req = 1'b1; // [R18]
        end
      end
      default: begin
        d.state = AD_IDLE;
      end
    endcase

    // Gain decode
    d.unipolar = q.gain[2] && !q.gain[3]; // [R2] [R3]
    d.bipolar = !d.unipolar;
    d.half = q.gain[3]; // [R2] [R3]
    if (HIGH_GAIN || !q.gain[3]) begin
      d.step = q.gain[1:0]; // [R3]
    end else begin
      d.step = 2'b00; // [R2]
    end

    // Channel decode
    if (q.sync2[PIN_DIFF]) begin
      d.mux_sel = {1'b0, q.chan[2:0]}; // [R5]
    end else begin
      d.mux_sel = q.chan; // [R5]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.mode <= MODE_OFF; // [R19]
      q.ready <= 1'b1;
      q.bipolar <= 1'b1;
      q.state <= AD_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign conv_start = q.conv_start;
  assign gain_code = q.gain;
  assign bipolar_range = q.bipolar;
  assign unipolar_range = q.unipolar;
  assign gain_step = q.step;
  assign gain_half = q.half;
  assign mux_sel = q.mux_sel;
  assign bus.io_rdata = q.rdata;
  assign bus.irq = q.irq_pend;
  assign bus.dma_req = q.dma_req;

endmodule

// ### sim/agt_props.sv
module agt_props
  import agt_pkg::*;
#(
  parameter int SETTLE_MIN = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Card bus
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic dma_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [17:0] settle_q;
  logic [17:0] settle_d;

  // Lower bound of the host settle wait
  always_comb begin
    settle_d = settle_q;
    if (settle_q != 18'h0) begin
      settle_d = settle_q - 18'h1;
    end
    if (io_wr && (io_addr == OFS_GAIN || io_addr == OFS_CHAN)) begin
      settle_d = 18'(SETTLE_MIN);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 18'h0;
    end else begin
      settle_q <= settle_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rd_zero_a: assert property (io_rd && io_addr != OFS_AD_LO && io_addr != OFS_AD_HI |=> io_rdata == BYTE_ZERO)
    else $error("unmapped card read gave data");
  rd_format_a: assert property (io_rd && io_addr == OFS_AD_HI |=> io_rdata[7:5] == 3'h0)
    else $error("high byte upper bits not zero");
  rd_hold_a: assert property (!io_rd && !dma_ack |=> $stable(io_rdata))
    else $error("read data changed without request");
  irq_clear_a: assert property ($fell(irq) |-> $past(io_wr) && $past(io_addr) == OFS_IRQ_CLR)
    else $error("interrupt dropped without clear write");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req)
    else $error("DMA request dropped before ack");
  dma_drop_a: assert property (dma_ack |=> !dma_req)
    else $error("DMA request held after ack");
  ack_gate_a: assert property (dma_ack |-> dma_req)
    else $error("DMA ack without request");
  rd_pulse_a: assert property (io_rd |=> !io_rd)
    else $error("read strobe longer than one cycle");
  settle_wait_a: assert property (io_wr && io_addr == OFS_STRIG |-> settle_q == 18'h0)
    else $error("trigger before settling");

  cover property (io_wr && io_addr == OFS_STRIG);
  cover property (dma_ack ##3 dma_ack);
  cover property ($rose(irq));
endmodule

// ### sim/tb_top.sv
module tb_top
  import agt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic conv_start, bipolar_range, unipolar_range, gain_half;
  logic conv_done = 1'b0;
  logic [RES_W-1:0] conv_data = 12'h000;
  logic [GAIN_W-1:0] gain_code;
  logic [1:0] gain_step;
  logic [CHAN_W-1:0] mux_sel;
  logic [8:0] gain_bus;
  logic trigger_source_jumper = 1'b0;
  logic diff_config = 1'b0;
  logic pacer_out = 1'b0;
  logic ext_trigger = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int n_starts = 0;
  int cdly = 0;

  assign gain_bus = {gain_code, bipolar_range, unipolar_range, gain_step, gain_half};

  agt_io_if bus();

  agt_host #(.GAIN_SETTLE_CYC(20), .MUX_SETTLE_CYC(10), .POLL_LIMIT(8)) i_agt_host (
    .clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_out, .bus(bus)
  );

  agt_dev #(.HIGH_GAIN(1'b0)) i_agt_dev (
    .clk, .rst, .ce, .bus(bus), .conv_start, .conv_done, .conv_data, .gain_code, .bipolar_range,
    .unipolar_range, .gain_step, .gain_half, .mux_sel, .trigger_source_jumper, .diff_config,
    .pacer_out, .ext_trigger
  );

  agt_props #(.SETTLE_MIN(10)) i_agt_props (
    .clk(clk), .rst(rst), .io_addr(bus.io_addr), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
    .io_rdata(bus.io_rdata), .irq(bus.irq), .dma_req(bus.dma_req), .dma_ack(bus.dma_ack)
  );

  always #5 clk = ~clk;

  // Converter: result five cycles after start
  always @(posedge clk) begin
    conv_done <= !conv_start && cdly == 1;
    if (conv_start) begin
      n_starts <= n_starts + 1;
      cdly <= 5;
    end else if (cdly > 0) begin
      cdly <= cdly - 1;
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 60) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    guard(n);
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    guard(n);
  endtask

  // Card command, then wait until the host is idle
  task automatic cmd(input logic [1:0] op, input logic [3:0] ofs, input logic [7:0] b);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    n = 0;
    axi_wr(HREG_CMD, {14'h0, op, b, 4'h0, ofs}, r);
    do begin
      axi_rd(HREG_STATUS, st, r);
      n++;
    end while (st[0] !== 1'b0 && n < 60);
    guard(n);
  endtask

  task automatic pulse(input logic ext);
    @(posedge clk);
    pacer_out <= !ext;
    ext_trigger <= ext;
    repeat (6) @(posedge clk);
    pacer_out <= 1'b0;
    ext_trigger <= 1'b0;
    repeat (40) @(posedge clk);
  endtask

  initial begin
    logic [31:0] v;
    logic [1:0] r;
    int s0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pulse(1'b0);
    cmd(OP_CONVERT, 4'h0, 8'h00);
    axi_rd(HREG_STATUS, v, r);
    check(v[1], 1'b1);
    check(n_starts, 0);
    axi_rd(HREG_EVENTS, v, r);
    check(v[EV_TIMEOUT], 1'b1);
    axi_rd(5'h14, v, r);
    check(r, RESP_SLVERR);
    $display("reset mode test done");
    for (int c = 0; c < 9; c++) begin
      cmd(OP_WRITE, OFS_GAIN, {4'hF, 4'(c)});
      check(gain_bus, {4'(c), !c[2], c[2], 2'(c), c[3]});
    end
    cmd(OP_WRITE, OFS_CHAN, 8'h5E);
    check(mux_sel, 4'hE);
    diff_config <= 1'b1;
    cmd(OP_WRITE, OFS_CHAN, 8'h0E);
    check(mux_sel, 4'h6);
    $display("gain and channel test done");
    cmd(OP_WRITE, OFS_MODE, 8'hF9);
    conv_data <= 12'hA5C;
    cmd(OP_WRITE, OFS_GAIN, 8'h01);
    s0 = n_starts;
    cmd(OP_CONVERT, 4'h0, 8'h00);
    axi_rd(HREG_STATUS, v, r);
    check(v[27:16], 12'hA5C);
    check(v[1], 1'b0);
    check(n_starts - s0, 1);
    cmd(OP_READ, OFS_AD_HI, 8'h00);
    axi_rd(HREG_STATUS, v, r);
    check(v[15:8], 8'h0A);
    cmd(OP_READ, OFS_GAIN, 8'h00);
    axi_rd(HREG_STATUS, v, r);
    check(v[15:8], BYTE_ZERO);
    $display("software trigger test done");
    cmd(OP_WRITE, OFS_MODE, 8'h02);
    conv_data <= 12'h3C7;
    s0 = n_starts;
    cmd(OP_WRITE, OFS_STRIG, 8'h00);
    pulse(1'b0);
    check(n_starts - s0, 1);
    axi_rd(HREG_DMA, v, r);
    check(v[11:0], 12'h3C7);
    axi_rd(HREG_EVENTS, v, r);
    check(v[EV_DMA], 1'b1);
    $display("pacer DMA test done");
    axi_wr(HREG_MASK, 32'h2, r);
    cmd(OP_WRITE, OFS_MODE, 8'h06);
    pulse(1'b0);
    check({irq_out, bus.irq}, 2'b11);
    cmd(OP_WRITE, OFS_IRQ_CLR, 8'h5A);
    check(bus.irq, 1'b0);
    axi_rd(HREG_EVENTS, v, r);
    check(v[EV_IRQ], 1'b1);
    repeat (2) @(posedge clk);
    check(irq_out, 1'b0);
    axi_wr(HREG_MASK, 32'h0, r);
    pulse(1'b0);
    check({irq_out, bus.irq}, 2'b01);
    cmd(OP_WRITE, OFS_IRQ_CLR, 8'h00);
    $display("interrupt test done");
    trigger_source_jumper <= 1'b1;
    s0 = n_starts;
    cmd(OP_WRITE, OFS_MODE, 8'h01);
    cmd(OP_WRITE, OFS_STRIG, 8'h00);
    pulse(1'b1);
    check(n_starts - s0, 0);
    cmd(OP_WRITE, OFS_MODE, 8'h02);
    conv_data <= 12'h81E;
    pulse(1'b0);
    check(n_starts - s0, 0);
    pulse(1'b1);
    check(n_starts - s0, 1);
    axi_rd(HREG_DMA, v, r);
    check(v[11:0], 12'h81E);
    $display("external trigger test done");
    finish_test();
  end
endmodule
